// >>> pkg/isu_pkg.sv
// Shared constants, register map and bus carrier for the interrupt status and mask unit
`default_nettype none
package isu_pkg;
	// Register bus widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int STATUS_W = 16;

	// Bit positions shared by status and mask
	localparam int BIT_EXT_FAST = 0;
	localparam int BIT_BATTERY_LOW = 1;
	localparam int BIT_WATCHDOG = 2;
	localparam int BIT_MEDIA_CHANGE = 3;
	localparam int BIT_CODEC = 4;
	localparam int BIT_EXT_ONE = 5;
	localparam int BIT_EXT_TWO = 6;
	localparam int BIT_EXT_THREE = 7;
	localparam int BIT_TIMER_ONE = 8;
	localparam int BIT_TIMER_TWO = 9;
	localparam int BIT_RTC_MATCH = 10;
	localparam int BIT_TICK = 11;
	localparam int BIT_UART_TX = 12;
	localparam int BIT_UART_RX = 13;
	localparam int BIT_MODEM = 14;
	localparam int BIT_SERIAL_EOT = 15;

	// Sources routed to the fast request; the rest go to the normal one
	localparam logic [STATUS_W-1:0] FAST_ROUTE = 16'h000F;
	localparam logic [STATUS_W-1:0] MASK_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] READ_ZERO = 16'h0000;

	// Register offsets
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_MASK = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_BATTERY_CLR = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_MEDIA_CLR = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_TICK_CLR = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_CODEC_CLR = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_TIMER_ONE_CLR = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_TIMER_TWO_CLR = 8'h1C;
	localparam logic [ADDR_W-1:0] OFS_RTC_CLR = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_MODEM_CLR = 8'h24;

	// Fast and normal request vector addresses, for software reference
	localparam logic [31:0] FAST_VECTOR = 32'h0000001C;
	localparam logic [31:0] NORMAL_VECTOR = 32'h00000018;

	// Synchronous prescaler fed by the 32.768 kHz enable
	localparam int PRESCALE_W = 15;
	localparam int TAP_16K = 0;
	localparam int TAP_64HZ = 8;
	localparam int TAP_1HZ = 14;

	// Deglitch window in samples of the 16 kHz filter clock
	localparam real DEGLITCH_TIME_MS = 62.5;
	localparam real FILTER_RATE_KHZ = 16.0;
	localparam int DEGLITCH_SAMPLES = $rtoi(DEGLITCH_TIME_MS * FILTER_RATE_KHZ);
	localparam int DEGLITCH_W = 10;
	localparam logic [DEGLITCH_W-1:0] DEGLITCH_LAST = DEGLITCH_W'(DEGLITCH_SAMPLES - 1);

	// Positions in the synchronised pin vector
	localparam int PIN_EXT_FAST_N = 0;
	localparam int PIN_EXT_ONE_N = 1;
	localparam int PIN_EXT_TWO_N = 2;
	localparam int PIN_EXT_THREE = 3;
	localparam int PIN_POWER_N = 4;
	localparam int PIN_BATTERY_GOOD = 5;
	localparam int PIN_MEDIA = 6;
	localparam int PIN_CTS = 7;
	localparam int PIN_DSR = 8;
	localparam int PIN_COUNT = 9;

	// One register bus request
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} isu_bus_req_s;
endpackage : isu_pkg
`default_nettype wire

// >>> src/isu_deglitch.sv
// Sampled deglitch filter: output rises only after a long unbroken high run
`default_nettype none
module isu_deglitch (
	input wire logic clk,
	input wire logic reset,
	input wire logic sample_en,
	input wire logic level_in,
	output logic level_out
);
	logic [isu_pkg::DEGLITCH_W-1:0] run_count;

	// Count consecutive high samples; any low sample restarts the window
	always_ff @(posedge clk) begin
		if (reset) begin
			run_count <= '0;
			level_out <= 1'b0;
		end else if (sample_en) begin
			if (!level_in) begin
				run_count <= '0;
				level_out <= 1'b0;
			end else if (run_count == isu_pkg::DEGLITCH_LAST) begin
				level_out <= 1'b1;
			end else begin
				run_count <= run_count + 1'b1;
			end
		end
	end
endmodule : isu_deglitch
`default_nettype wire

// >>> src/isu_top.sv
// Interrupt status and mask unit: sixteen sources, fast and normal request lines
`default_nettype none
module isu_top (
	input wire logic clk,
	input wire logic reset,
	input wire isu_pkg::isu_bus_req_s bus_req,
	output logic [isu_pkg::DATA_W-1:0] rd_data,
	input wire logic ext_fast_request_pin_n,
	input wire logic external_pin_one_n,
	input wire logic external_pin_two_n,
	input wire logic external_pin_three,
	input wire logic external_power_sense_n,
	input wire logic battery_good_pin,
	input wire logic media_change_pin,
	input wire logic uart_cts_pin,
	input wire logic uart_dsr_pin,
	input wire logic osc_32k_en,
	input wire logic codec_enabled,
	input wire logic codec_tx_dir,
	input wire logic codec_fifo_half_full,
	input wire logic codec_fifo_empty,
	input wire logic timer_one_clk_en,
	input wire logic timer_one_zero,
	input wire logic timer_two_clk_en,
	input wire logic timer_two_zero,
	input wire logic [31:0] rtc_time,
	input wire logic [31:0] rtc_match_value,
	input wire logic uart_queue_enable,
	input wire logic uart_tx_holding_empty,
	input wire logic uart_tx_half_empty,
	input wire logic uart_rx_holding_valid,
	input wire logic uart_rx_half_full,
	input wire logic uart_rx_nonempty,
	input wire logic uart_rx_timeout,
	input wire logic serial_transfer_done,
	input wire logic serial_data_read,
	output logic one_hz_tick,
	output logic core_fast_request_n,
	output logic core_normal_request_n
);
	logic [isu_pkg::PIN_COUNT-1:0] pin_raw;
	logic [isu_pkg::PIN_COUNT-1:0] pin_meta;
	logic [isu_pkg::PIN_COUNT-1:0] pin_sync;
	logic [isu_pkg::PRESCALE_W-1:0] prescale;
	logic [isu_pkg::PRESCALE_W-1:0] next_prescale;
	logic tick_16k;
	logic tick_64hz;
	logic tick_1hz;
	logic battery_cond;
	logic battery_filtered;
	logic battery_filtered_q;
	logic media_filtered;
	logic media_filtered_q;
	logic battery_low_source;
	logic media_change_source;
	logic watchdog_expired_source;
	logic periodic_tick_source;
	logic codec_sound_source;
	logic codec_level;
	logic timer_one_underflow_source;
	logic timer_two_underflow_source;
	logic timer_one_zero_seen;
	logic timer_two_zero_seen;
	logic rtc_match_source;
	logic rtc_equal_q;
	logic modem_status_source;
	logic cts_q;
	logic dsr_q;
	logic [2:0] modem_settle;
	logic serial_end_transfer_source;
	logic [isu_pkg::STATUS_W-1:0] interrupt_source_status;
	logic [isu_pkg::STATUS_W-1:0] interrupt_enable_mask;
	logic [isu_pkg::STATUS_W-1:0] pending;
	logic wr_battery_clr;
	logic wr_media_clr;
	logic wr_tick_clr;
	logic wr_codec_clr;
	logic wr_timer_one_clr;
	logic wr_timer_two_clr;
	logic wr_rtc_clr;
	logic wr_modem_clr;

	// Gather asynchronous pins into one vector for the synchroniser
	assign pin_raw[isu_pkg::PIN_EXT_FAST_N] = ext_fast_request_pin_n;
	assign pin_raw[isu_pkg::PIN_EXT_ONE_N] = external_pin_one_n;
	assign pin_raw[isu_pkg::PIN_EXT_TWO_N] = external_pin_two_n;
	assign pin_raw[isu_pkg::PIN_EXT_THREE] = external_pin_three;
	assign pin_raw[isu_pkg::PIN_POWER_N] = external_power_sense_n;
	assign pin_raw[isu_pkg::PIN_BATTERY_GOOD] = battery_good_pin;
	assign pin_raw[isu_pkg::PIN_MEDIA] = media_change_pin;
	assign pin_raw[isu_pkg::PIN_CTS] = uart_cts_pin;
	assign pin_raw[isu_pkg::PIN_DSR] = uart_dsr_pin;

	// Two flops per pin; only the second stage is ever read
	for (genvar i = 0; i < isu_pkg::PIN_COUNT; i++) begin : g_sync
		always_ff @(posedge clk) begin
			if (reset) begin
				pin_meta[i] <= 1'b0;
				pin_sync[i] <= 1'b0;
			end else begin
				pin_meta[i] <= pin_raw[i];
				pin_sync[i] <= pin_meta[i];
			end
		end
	end

	// Prescaler advance and its rising-edge taps
	always_comb begin
		next_prescale = prescale + 1'b1;
		tick_16k = osc_32k_en && !prescale[isu_pkg::TAP_16K] && next_prescale[isu_pkg::TAP_16K];
		tick_64hz = osc_32k_en && !prescale[isu_pkg::TAP_64HZ] && next_prescale[isu_pkg::TAP_64HZ];
		tick_1hz = osc_32k_en && !prescale[isu_pkg::TAP_1HZ] && next_prescale[isu_pkg::TAP_1HZ];
	end

	// Counted synchronously so every tap is a clean one-cycle enable
	always_ff @(posedge clk) begin
		if (reset) begin
			prescale <= '0;
			one_hz_tick <= 1'b0;
		end else begin
			one_hz_tick <= tick_1hz;
			if (osc_32k_en) begin
				prescale <= next_prescale;
			end
		end
	end

	// No external supply and battery not good
	assign battery_cond = pin_sync[isu_pkg::PIN_POWER_N] && !pin_sync[isu_pkg::PIN_BATTERY_GOOD];

	// Both slow filters share the 16 kHz sample enable
	isu_deglitch u_battery_filter (
		.clk(clk),
		.reset(reset),
		.sample_en(tick_16k),
		.level_in(battery_cond),
		.level_out(battery_filtered)
	);

	// Media pin needs the same long high run before it counts
	isu_deglitch u_media_filter (
		.clk(clk),
		.reset(reset),
		.sample_en(tick_16k),
		.level_in(pin_sync[isu_pkg::PIN_MEDIA]),
		.level_out(media_filtered)
	);

	// Clear locations: a write with any data clears the matching source
	always_comb begin
		wr_battery_clr = bus_req.wr && (bus_req.addr == isu_pkg::OFS_BATTERY_CLR);
		wr_media_clr = bus_req.wr && (bus_req.addr == isu_pkg::OFS_MEDIA_CLR);
		wr_tick_clr = bus_req.wr && (bus_req.addr == isu_pkg::OFS_TICK_CLR);
		wr_codec_clr = bus_req.wr && (bus_req.addr == isu_pkg::OFS_CODEC_CLR);
		wr_timer_one_clr = bus_req.wr && (bus_req.addr == isu_pkg::OFS_TIMER_ONE_CLR);
		wr_timer_two_clr = bus_req.wr && (bus_req.addr == isu_pkg::OFS_TIMER_TWO_CLR);
		wr_rtc_clr = bus_req.wr && (bus_req.addr == isu_pkg::OFS_RTC_CLR);
		wr_modem_clr = bus_req.wr && (bus_req.addr == isu_pkg::OFS_MODEM_CLR);
	end

	// Battery and media latch on the filtered rising edge; set beats clear
	always_ff @(posedge clk) begin
		if (reset) begin
			battery_filtered_q <= 1'b0;
			media_filtered_q <= 1'b0;
			battery_low_source <= 1'b0;
			media_change_source <= 1'b0;
		end else begin
			battery_filtered_q <= battery_filtered;
			media_filtered_q <= media_filtered;
			if (battery_filtered && !battery_filtered_q) begin
				battery_low_source <= 1'b1;
			end else if (wr_battery_clr) begin
				battery_low_source <= 1'b0;
			end
			if (media_filtered && !media_filtered_q) begin
				media_change_source <= 1'b1;
			end else if (wr_media_clr) begin
				media_change_source <= 1'b0;
			end
		end
	end

	// Tick and watchdog share one clear; watchdog samples the old tick flag
	always_ff @(posedge clk) begin
		if (reset) begin
			periodic_tick_source <= 1'b0;
			watchdog_expired_source <= 1'b0;
		end else begin
			if (tick_64hz) begin
				periodic_tick_source <= 1'b1;
			end else if (wr_tick_clr) begin
				periodic_tick_source <= 1'b0;
			end
			if (tick_64hz && periodic_tick_source) begin
				watchdog_expired_source <= 1'b1;
			end else if (wr_tick_clr) begin
				watchdog_expired_source <= 1'b0;
			end
		end
	end

	// Playback waits for empty, capture for half full
	assign codec_level = codec_enabled && (codec_tx_dir ? codec_fifo_empty : codec_fifo_half_full);

	// Codec flag stays latched until written, re-set while the level holds
	always_ff @(posedge clk) begin
		if (reset) begin
			codec_sound_source <= 1'b0;
		end else if (codec_level) begin
			codec_sound_source <= 1'b1;
		end else if (wr_codec_clr) begin
			codec_sound_source <= 1'b0;
		end
	end

	// Zero is noted on one timer clock and flagged on the next
	always_ff @(posedge clk) begin
		if (reset) begin
			timer_one_zero_seen <= 1'b0;
			timer_two_zero_seen <= 1'b0;
			timer_one_underflow_source <= 1'b0;
			timer_two_underflow_source <= 1'b0;
		end else begin
			if (timer_one_clk_en) begin
				timer_one_zero_seen <= timer_one_zero;
			end
			if (timer_two_clk_en) begin
				timer_two_zero_seen <= timer_two_zero;
			end
			if (timer_one_clk_en && timer_one_zero_seen) begin
				timer_one_underflow_source <= 1'b1;
			end else if (wr_timer_one_clr) begin
				timer_one_underflow_source <= 1'b0;
			end
			if (timer_two_clk_en && timer_two_zero_seen) begin
				timer_two_underflow_source <= 1'b1;
			end else if (wr_timer_two_clr) begin
				timer_two_underflow_source <= 1'b0;
			end
		end
	end

	// Compare registered to keep the 32-bit equality off the flag path
	always_ff @(posedge clk) begin
		if (reset) begin
			rtc_equal_q <= 1'b0;
			rtc_match_source <= 1'b0;
		end else begin
			rtc_equal_q <= (rtc_time == rtc_match_value);
			if (tick_1hz && rtc_equal_q) begin
				rtc_match_source <= 1'b1;
			end else if (wr_rtc_clr) begin
				rtc_match_source <= 1'b0;
			end
		end
	end

	// Modem lines compared with their last synchronised value
	always_ff @(posedge clk) begin
		if (reset) begin
			cts_q <= 1'b0;
			dsr_q <= 1'b0;
			modem_settle <= '0;
			modem_status_source <= 1'b0;
		end else begin
			cts_q <= pin_sync[isu_pkg::PIN_CTS];
			dsr_q <= pin_sync[isu_pkg::PIN_DSR];
			modem_settle <= {modem_settle[1:0], 1'b1}; // No false change after reset
			if (modem_settle[2] && ((cts_q != pin_sync[isu_pkg::PIN_CTS]) ||
				(dsr_q != pin_sync[isu_pkg::PIN_DSR]))) begin
				modem_status_source <= 1'b1;
			end else if (wr_modem_clr) begin
				modem_status_source <= 1'b0;
			end
		end
	end

	// Serial flag is cleared by the data read in the serial block
	always_ff @(posedge clk) begin
		if (reset) begin
			serial_end_transfer_source <= 1'b0;
		end else if (serial_transfer_done) begin
			serial_end_transfer_source <= 1'b1;
		end else if (serial_data_read) begin
			serial_end_transfer_source <= 1'b0;
		end
	end

	// Assemble the status word; level sources follow their inputs directly
	always_comb begin
		interrupt_source_status = '0;
		interrupt_source_status[isu_pkg::BIT_EXT_FAST] = !pin_sync[isu_pkg::PIN_EXT_FAST_N];
		interrupt_source_status[isu_pkg::BIT_BATTERY_LOW] = battery_low_source;
		interrupt_source_status[isu_pkg::BIT_WATCHDOG] = watchdog_expired_source;
		interrupt_source_status[isu_pkg::BIT_MEDIA_CHANGE] = media_change_source;
		interrupt_source_status[isu_pkg::BIT_CODEC] = codec_sound_source;
		interrupt_source_status[isu_pkg::BIT_EXT_ONE] = !pin_sync[isu_pkg::PIN_EXT_ONE_N];
		interrupt_source_status[isu_pkg::BIT_EXT_TWO] = !pin_sync[isu_pkg::PIN_EXT_TWO_N];
		interrupt_source_status[isu_pkg::BIT_EXT_THREE] = pin_sync[isu_pkg::PIN_EXT_THREE];
		interrupt_source_status[isu_pkg::BIT_TIMER_ONE] = timer_one_underflow_source;
		interrupt_source_status[isu_pkg::BIT_TIMER_TWO] = timer_two_underflow_source;
		interrupt_source_status[isu_pkg::BIT_RTC_MATCH] = rtc_match_source;
		interrupt_source_status[isu_pkg::BIT_TICK] = periodic_tick_source;
		interrupt_source_status[isu_pkg::BIT_UART_TX] = uart_queue_enable ?
			uart_tx_half_empty : uart_tx_holding_empty;
		interrupt_source_status[isu_pkg::BIT_UART_RX] = uart_queue_enable ?
			(uart_rx_half_full || (uart_rx_nonempty && uart_rx_timeout)) :
			uart_rx_holding_valid;
		interrupt_source_status[isu_pkg::BIT_MODEM] = modem_status_source;
		interrupt_source_status[isu_pkg::BIT_SERIAL_EOT] = serial_end_transfer_source;
	end

	// Mask register, cleared by reset
	always_ff @(posedge clk) begin
		if (reset) begin
			interrupt_enable_mask <= isu_pkg::MASK_RESET;
		end else if (bus_req.wr && (bus_req.addr == isu_pkg::OFS_MASK)) begin
			interrupt_enable_mask <= bus_req.wdata;
		end
	end

	// Mask gates only the requests, never the status view
	assign pending = interrupt_source_status & interrupt_enable_mask;

	// Active-low request lines, registered so outputs come from flops
	always_ff @(posedge clk) begin
		if (reset) begin
			core_fast_request_n <= 1'b1;
			core_normal_request_n <= 1'b1;
		end else begin
			core_fast_request_n <= !(|(pending & isu_pkg::FAST_ROUTE));
			core_normal_request_n <= !(|(pending & ~isu_pkg::FAST_ROUTE));
		end
	end

	// Read data valid only in the cycle after the strobe; unmapped reads zero
	always_ff @(posedge clk) begin
		if (reset) begin
			rd_data <= isu_pkg::READ_ZERO;
		end else if (bus_req.rd) begin
			case (bus_req.addr)
				isu_pkg::OFS_STATUS: rd_data <= interrupt_source_status;
				isu_pkg::OFS_MASK: rd_data <= interrupt_enable_mask;
				default: rd_data <= isu_pkg::READ_ZERO;
			endcase
		end else begin
			rd_data <= isu_pkg::READ_ZERO;
		end
	end
endmodule : isu_top
`default_nettype wire

// >>> bench/isu_top_props.sv
// Port-level checks for the interrupt status and mask unit
`default_nettype none
module isu_top_props (
	input wire logic clk,
	input wire logic reset,
	input wire isu_pkg::isu_bus_req_s bus_req,
	input wire logic [isu_pkg::DATA_W-1:0] rd_data,
	input wire logic ext_fast_request_pin_n,
	input wire logic external_pin_one_n,
	input wire logic external_pin_three,
	input wire logic one_hz_tick,
	input wire logic core_fast_request_n,
	input wire logic core_normal_request_n
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	logic [isu_pkg::STATUS_W-1:0] shadow;
	// Mask copy rebuilt from bus writes, since the mask is not a port
	always_ff @(posedge clk) begin
		if (reset) shadow <= isu_pkg::MASK_RESET;
		else if (bus_req.wr && bus_req.addr == isu_pkg::OFS_MASK) shadow <= bus_req.wdata;
	end
	// Named steps; only the status read and pin-three run are shared
	sequence s_rd_status;
		bus_req.rd && bus_req.addr == isu_pkg::OFS_STATUS;
	endsequence
	sequence s_rd_mask;
		bus_req.rd && bus_req.addr == isu_pkg::OFS_MASK;
	endsequence
	sequence s_fast_low;
		!ext_fast_request_pin_n [*4];
	endsequence
	sequence s_three_high;
		external_pin_three [*4];
	endsequence
	a_read_idle_zero: assert property (!bus_req.rd |=> rd_data == isu_pkg::READ_ZERO)
		else $error("read data not zero after idle cycle");
	a_mask_read_back: assert property (s_rd_mask |=> rd_data == $past(shadow))
		else $error("mask read differs from last write");
	a_fast_masked_off: assert property ((shadow & isu_pkg::FAST_ROUTE) == isu_pkg::MASK_RESET
		|=> core_fast_request_n)
		else $error("fast request with fast sources masked");
	a_normal_masked_off: assert property ((shadow & ~isu_pkg::FAST_ROUTE) == isu_pkg::MASK_RESET
		|=> core_normal_request_n)
		else $error("normal request with normal sources masked");
	a_ext_one_set: assert property ((!external_pin_one_n [*4]) ##0 s_rd_status
		|=> rd_data[isu_pkg::BIT_EXT_ONE])
		else $error("low pin one not shown in status");
	a_ext_one_clear: assert property ((external_pin_one_n [*6]) ##0 s_rd_status
		|=> !rd_data[isu_pkg::BIT_EXT_ONE])
		else $error("high pin one still shown in status");
	a_ext_three_set: assert property (s_three_high ##0 s_rd_status
		|=> rd_data[isu_pkg::BIT_EXT_THREE])
		else $error("high pin three not shown in status");
	a_fast_route_on: assert property (s_fast_low ##0 shadow[isu_pkg::BIT_EXT_FAST]
		|=> !core_fast_request_n)
		else $error("enabled fast pin gives no fast request");
	a_normal_route_on: assert property (s_three_high ##0 shadow[isu_pkg::BIT_EXT_THREE]
		|=> !core_normal_request_n)
		else $error("enabled pin three gives no normal request");
	a_second_pulse_once: assert property (one_hz_tick |=> !one_hz_tick)
		else $error("one second pulse longer than a cycle");
endmodule : isu_top_props
bind isu_top isu_top_props u_isu_top_props (.clk, .reset, .bus_req, .rd_data,
	.ext_fast_request_pin_n, .external_pin_one_n, .external_pin_three, .one_hz_tick,
	.core_fast_request_n, .core_normal_request_n);
`default_nettype wire

// >>> bench/isu_core_model.sv
// Processor core stand-in: records which vector it would jump to
`default_nettype none
module isu_core_model (
	input wire logic clk,
	input wire logic reset,
	input wire logic core_fast_request_n,
	input wire logic core_normal_request_n,
	output logic [31:0] vector
);
	timeunit 1ns;
	timeprecision 1ns;
	// Fast request outranks normal, as the core takes it first
	always_ff @(posedge clk) begin
		if (reset) vector <= 32'h00000000;
		else if (!core_fast_request_n) vector <= isu_pkg::FAST_VECTOR;
		else if (!core_normal_request_n) vector <= isu_pkg::NORMAL_VECTOR;
		else vector <= 32'h00000000;
	end
endmodule : isu_core_model
`default_nettype wire

// >>> bench/tb_top.sv
// Self-checking bench for the interrupt status and mask unit
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
		$display("wrong value %s expected %h seen %h", n, e, g); end end
	logic clk, reset = 1'b1;
	isu_pkg::isu_bus_req_s bus_req = '0;
	logic [isu_pkg::DATA_W-1:0] rd_data, d;
	logic one_hz_tick, core_fast_request_n, core_normal_request_n;
	logic ext_fast_request_pin_n = 1'b1, external_pin_one_n = 1'b1, external_pin_two_n = 1'b1;
	logic external_pin_three = '0, external_power_sense_n = '0, battery_good_pin = 1'b1;
	logic media_change_pin = '0, uart_cts_pin = '0, uart_dsr_pin = '0, osc_32k_en = '0;
	logic codec_enabled = '0, codec_tx_dir = '0, codec_fifo_half_full = '0, codec_fifo_empty = '0;
	logic timer_one_clk_en = '0, timer_one_zero = '0, timer_two_clk_en = '0, timer_two_zero = '0;
	logic [31:0] rtc_time = '0, rtc_match_value = 32'h00000001, vector;
	logic uart_queue_enable = '0, uart_tx_holding_empty = '0, uart_tx_half_empty = '0;
	logic uart_rx_holding_valid = '0, uart_rx_half_full = '0, uart_rx_nonempty = '0;
	logic uart_rx_timeout = '0, serial_transfer_done = '0, serial_data_read = '0;
	int mismatches = 0;
	int tests_run = 0;
	int one_hz_seen = 0;
	isu_top u_isu_top (.clk, .reset, .bus_req, .rd_data, .ext_fast_request_pin_n,
		.external_pin_one_n, .external_pin_two_n, .external_pin_three, .external_power_sense_n,
		.battery_good_pin, .media_change_pin, .uart_cts_pin, .uart_dsr_pin, .osc_32k_en,
		.codec_enabled, .codec_tx_dir, .codec_fifo_half_full, .codec_fifo_empty,
		.timer_one_clk_en, .timer_one_zero, .timer_two_clk_en, .timer_two_zero, .rtc_time,
		.rtc_match_value, .uart_queue_enable, .uart_tx_holding_empty, .uart_tx_half_empty,
		.uart_rx_holding_valid, .uart_rx_half_full, .uart_rx_nonempty, .uart_rx_timeout,
		.serial_transfer_done, .serial_data_read, .one_hz_tick, .core_fast_request_n,
		.core_normal_request_n);
	isu_core_model u_isu_core_model (.clk, .reset, .core_fast_request_n,
		.core_normal_request_n, .vector);
	// Count one second pulses mid-cycle, once settled
	always @(negedge clk) if (one_hz_tick === 1'b1) one_hz_seen++;
	// Free-running 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	// One-cycle write strobe
	task automatic wr(input logic [isu_pkg::ADDR_W-1:0] a, input logic [15:0] v);
		@(posedge clk);
		bus_req <= '{a, v, 1'b1, 1'b0};
		@(posedge clk);
		bus_req.wr <= 1'b0;
	endtask : wr
	// Read strobe; data stand only in the following cycle
	task automatic rd(input logic [isu_pkg::ADDR_W-1:0] a);
		@(posedge clk);
		bus_req <= '{a, 16'h0000, 1'b0, 1'b1};
		@(posedge clk);
		bus_req.rd <= 1'b0;
		#1 d = rd_data;
	endtask : rd
	task automatic t_regs();
		rd(isu_pkg::OFS_MASK);
		`CHK("mask", isu_pkg::MASK_RESET, d)
		`CHK("fast_n", 1'b1, core_fast_request_n)
		`CHK("normal_n", 1'b1, core_normal_request_n)
		wr(isu_pkg::OFS_MASK, 16'hA5C3);
		rd(isu_pkg::OFS_MASK);
		`CHK("mask", 16'hA5C3, d)
		wr(isu_pkg::OFS_STATUS, 16'hFFFF);
		rd(isu_pkg::OFS_STATUS);
		`CHK("status", 16'h0000, d)
		rd(8'hFC);
		`CHK("unmapped", 16'h0000, d)
		wr(isu_pkg::OFS_MASK, 16'h00E1);
	endtask : t_regs
	task automatic t_pins();
		ext_fast_request_pin_n <= 1'b0;
		cyc(4);
		rd(isu_pkg::OFS_STATUS);
		`CHK("status", 16'h0001, d)
		`CHK("fast_n", 1'b0, core_fast_request_n)
		`CHK("normal_n", 1'b1, core_normal_request_n)
		`CHK("vector", isu_pkg::FAST_VECTOR, vector)
		ext_fast_request_pin_n <= 1'b1;
		external_pin_one_n <= 1'b0;
		cyc(4);
		rd(isu_pkg::OFS_STATUS);
		`CHK("status", 16'h0020, d)
		`CHK("normal_n", 1'b0, core_normal_request_n)
		`CHK("vector", isu_pkg::NORMAL_VECTOR, vector)
		// Every clear location leaves a pin-held source standing
		for (int i = 2; i < 10; i++) wr(8'(i * 4), 16'hFFFF);
		wr(isu_pkg::OFS_MASK, 16'h0000);
		cyc(2);
		rd(isu_pkg::OFS_STATUS);
		`CHK("status", 16'h0020, d)
		`CHK("normal_n", 1'b1, core_normal_request_n)
		wr(isu_pkg::OFS_MASK, 16'h00E1);
		external_pin_one_n <= 1'b1;
		external_pin_two_n <= 1'b0;
		cyc(4);
		rd(isu_pkg::OFS_STATUS);
		`CHK("status", 16'h0040, d)
		external_pin_two_n <= 1'b1;
		external_pin_three <= 1'b1;
		cyc(4);
		rd(isu_pkg::OFS_STATUS);
		`CHK("status", 16'h0080, d)
		external_pin_three <= 1'b0;
		cyc(4);
		rd(isu_pkg::OFS_STATUS);
		`CHK("status", 16'h0000, d)
		`CHK("normal_n", 1'b1, core_normal_request_n)
	endtask : t_pins
	task automatic pulse_timers();
		timer_one_clk_en <= 1'b1;
		timer_two_clk_en <= 1'b1;
		@(posedge clk);
		timer_one_clk_en <= 1'b0;
		timer_two_clk_en <= 1'b0;
		cyc(2);
	endtask : pulse_timers
	task automatic t_timers();
		wr(isu_pkg::OFS_MASK, 16'h0300);
		timer_one_zero <= 1'b1;
		timer_two_zero <= 1'b1;
		pulse_timers();
		timer_one_zero <= 1'b0;
		timer_two_zero <= 1'b0;
		rd(isu_pkg::OFS_STATUS);
		`CHK("status", 16'h0000, d)
		pulse_timers();
		rd(isu_pkg::OFS_STATUS);
		`CHK("status", 16'h0300, d)
		`CHK("normal_n", 1'b0, core_normal_request_n)
		wr(isu_pkg::OFS_TIMER_ONE_CLR, 16'h0000);
		rd(isu_pkg::OFS_STATUS);
		`CHK("status", 16'h0200, d)
		wr(isu_pkg::OFS_TIMER_TWO_CLR, 16'h0000);
		rd(isu_pkg::OFS_STATUS);
		`CHK("status", 16'h0000, d)
	endtask : t_timers
	task automatic t_sources();
		{codec_enabled, codec_tx_dir, codec_fifo_empty} <= 3'h7;
		cyc(2);
		rd(isu_pkg::OFS_STATUS);
		`CHK("codec", 1'b1, d[isu_pkg::BIT_CODEC])
		{codec_fifo_empty, codec_fifo_half_full} <= 2'h1;
		wr(isu_pkg::OFS_CODEC_CLR, 16'h0000);
		rd(isu_pkg::OFS_STATUS);
		`CHK("codec", 1'b0, d[isu_pkg::BIT_CODEC])
		codec_tx_dir <= 1'b0;
		cyc(2);
		rd(isu_pkg::OFS_STATUS);
		`CHK("codec", 1'b1, d[isu_pkg::BIT_CODEC])
		codec_enabled <= 1'b0;
		wr(isu_pkg::OFS_CODEC_CLR, 16'h0000);
		rd(isu_pkg::OFS_STATUS);
		`CHK("codec", 1'b0, d[isu_pkg::BIT_CODEC])
		// Every combination of queue mode and levels
		for (int i = 0; i < 8; i++) begin
			{uart_queue_enable, uart_tx_holding_empty, uart_tx_half_empty} <= 3'(i);
			cyc(2);
			rd(isu_pkg::OFS_STATUS);
			`CHK("uart_tx", i[2] ? i[0] : i[1], d[isu_pkg::BIT_UART_TX])
		end
		for (int i = 0; i < 32; i++) begin
			{uart_queue_enable, uart_rx_holding_valid, uart_rx_half_full, uart_rx_nonempty,
				uart_rx_timeout} <= 5'(i);
			cyc(2);
			rd(isu_pkg::OFS_STATUS);
			`CHK("uart_rx", i[4] ? i[2] | (i[1] & i[0]) : i[3], d[isu_pkg::BIT_UART_RX])
		end
		{uart_queue_enable, uart_rx_holding_valid, uart_rx_half_full} <= 3'h0;
		for (int j = 0; j < 2; j++) begin
			if (j == 0) uart_cts_pin <= 1'b1;
			else uart_dsr_pin <= 1'b1;
			cyc(4);
			rd(isu_pkg::OFS_STATUS);
			`CHK("modem", 1'b1, d[isu_pkg::BIT_MODEM])
			wr(isu_pkg::OFS_MODEM_CLR, 16'h0000);
			rd(isu_pkg::OFS_STATUS);
			`CHK("modem", 1'b0, d[isu_pkg::BIT_MODEM])
		end
		serial_transfer_done <= 1'b1;
		@(posedge clk);
		serial_transfer_done <= 1'b0;
		rd(isu_pkg::OFS_STATUS);
		`CHK("serial", 1'b1, d[isu_pkg::BIT_SERIAL_EOT])
		serial_data_read <= 1'b1;
		@(posedge clk);
		serial_data_read <= 1'b0;
		rd(isu_pkg::OFS_STATUS);
		`CHK("serial", 1'b0, d[isu_pkg::BIT_SERIAL_EOT])
	endtask : t_sources
	// Oscillator enable every cycle: 64 Hz at 256 then every 512, 1 Hz at 16384
	task automatic t_prescale();
		wr(isu_pkg::OFS_MASK, 16'h0C0E);
		{osc_32k_en, external_power_sense_n, battery_good_pin, media_change_pin} <= 4'hD;
		rtc_time <= 32'h00001234;
		rtc_match_value <= 32'h00001234;
		cyc(300);
		rd(isu_pkg::OFS_STATUS);
		`CHK("tick_wd_batt", 3'h4, {d[isu_pkg::BIT_TICK], d[2:1]})
		cyc(500);
		rd(isu_pkg::OFS_STATUS);
		`CHK("watchdog", 1'b1, d[isu_pkg::BIT_WATCHDOG])
		`CHK("fast_n", 1'b0, core_fast_request_n)
		wr(isu_pkg::OFS_TICK_CLR, 16'h0000);
		rd(isu_pkg::OFS_STATUS);
		`CHK("tick_wd", 2'h0, {d[isu_pkg::BIT_TICK], d[isu_pkg::BIT_WATCHDOG]})
		cyc(1100);
		rd(isu_pkg::OFS_STATUS);
		`CHK("batt_media", 2'h0, {d[isu_pkg::BIT_MEDIA_CHANGE], d[1]})
		cyc(200);
		rd(isu_pkg::OFS_STATUS);
		`CHK("batt_media", 2'h3, {d[isu_pkg::BIT_MEDIA_CHANGE], d[1]})
		wr(isu_pkg::OFS_BATTERY_CLR, 16'h0000);
		wr(isu_pkg::OFS_MEDIA_CLR, 16'h0000);
		rd(isu_pkg::OFS_STATUS);
		`CHK("batt_media", 2'h0, {d[isu_pkg::BIT_MEDIA_CHANGE], d[1]})
		cyc(14100);
		rd(isu_pkg::OFS_STATUS);
		`CHK("rtc", 1'b0, d[isu_pkg::BIT_RTC_MATCH])
		cyc(300);
		rd(isu_pkg::OFS_STATUS);
		`CHK("rtc", 1'b1, d[isu_pkg::BIT_RTC_MATCH])
		`CHK("one_hz", 1, one_hz_seen)
		wr(isu_pkg::OFS_RTC_CLR, 16'h0000);
		rtc_match_value <= 32'h00001235;
		cyc(32800);
		rd(isu_pkg::OFS_STATUS);
		`CHK("rtc", 1'b0, d[isu_pkg::BIT_RTC_MATCH])
		`CHK("one_hz", 2, one_hz_seen)
		osc_32k_en <= 1'b0;
	endtask : t_prescale
	task automatic conclude();
		if (mismatches == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : conclude
	// Hang guard, well past the roughly 50000 cycles of the run
	initial begin
		#3000000;
		mismatches++;
		conclude();
	end
	initial begin
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		cyc(4);
		t_regs();
		t_pins();
		t_timers();
		t_sources();
		t_prescale();
		conclude();
	end
endmodule : tb_top
`default_nettype wire
